//--- timer_compare_capture_pwm.sv
// Timer with compare, capture, buffer and PWM behind an AXI4-Lite slave
`timescale 1ns/1ns
`include "timer_consts.svh"
// Operation
// - After reset counter is stopped, counting only while start bit is 1
// - Wrap from all ones to zero sets overflow flag, requests irq if enabled
// - Match A with clear enabled in compare mode clears counter to zero
// - Match A sets match flag A and requests irq if enabled
// - Cleared by A holding N the counter counts 0..N, period N+1
// - Compare match drives pin 0, 1 or toggles per output control
// - Pin already at selected level stays unchanged at match
// - Capture register stores counter on selected pin edge
// - C buffering A: capture moves A into C and counter into A
// - PWM: A sets period, B, C, D set duty of pins B, C, D
// - In PWM, A and the duty registers of PWM pins act as compare registers
// - PWM pin: init 1 goes 1 at match A, 0 at duty; reversed for 0
// - PWM pins ignore per-register compare output selections
// - Duty equal to period leaves PWM output unchanged
// - D buffering B: match B changes pin and copies D into B
// - Match takes effect only as counter advances off matching value
// - Compare mode sets match flag at the delayed compare match
// - Capture mode sets match flag when the capture occurs
// - Flag clears only after being read as 1 then written 0
// - Compare control: 00 none, 01 drive 0, 10 drive 1, 11 toggle
// - Capture control: 00 rising, 01 falling, 1X both edges
// - C buffering A in compare: C copies into A at every match A
// - Reset sets all four general registers to all ones
module timer_compare_capture_pwm (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        ext_count_in,
    input  wire logic [3:0]  timer_pin_in,
    output logic [3:0]       timer_pin_out,
    output logic [3:0]       timer_pin_oe,
    output logic             timer_irq_request
);
    localparam timer_pkg::timer_state_s ST_RESET = '{
        counter: `RST_CNT,
        gr:      {4{`RST_GR}},
        default: '0
    };

    timer_pkg::timer_state_s st;
    timer_pkg::timer_state_s next_st;
    timer_pkg::wr_req_s      wreq;
    timer_pkg::wr_req_s      next_wreq;
    timer_pkg::bus_state_e   wr_state;
    timer_pkg::bus_state_e   next_wr_state;
    timer_pkg::bus_state_e   rd_state;
    timer_pkg::bus_state_e   next_rd_state;
    logic        aw_full;
    logic        next_aw_full;
    logic        w_full;
    logic        next_w_full;
    logic        next_awready;
    logic        next_wready;
    logic [1:0]  next_bresp;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        wr_do;
    logic        rd_do;
    logic        cnt_wr;
    logic [31:0] wimg;
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [3:0]  pin_s3;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic        tick;
    logic [3:0]  pwm;
    logic [3:0]  active;
    logic [3:0]  cap_mode;
    logic [3:0]  cap_ev;
    logic [3:0]  match;
    logic [3:0]  edge_seen;

    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `OFS_MODE, `OFS_CONTROL, `OFS_IRQ_EN, `OFS_STATUS,
            `OFS_IO_AB, `OFS_IO_CD, `OFS_COUNTER,
            `OFS_GR_A, `OFS_GR_B, `OFS_GR_C, `OFS_GR_D: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] reg_read(
        input timer_pkg::timer_state_s s,
        input logic [7:0]              a
    );
        reg_read = '0;
        case (a)
            `OFS_MODE:    reg_read[`MODE_W-1:0] = s.mode;
            `OFS_CONTROL: reg_read[`CTL_W-1:0] = s.control;
            `OFS_IRQ_EN:  reg_read[`FLAG_W-1:0] = s.irq_en;
            `OFS_STATUS:  reg_read[`FLAG_W-1:0] = s.status;
            `OFS_IO_AB:   reg_read[`IO_BYTE_W-1:0] =
                              {`IO_RSVD, s.io[1], `IO_RSVD, s.io[0]};
            `OFS_IO_CD:   reg_read[`IO_BYTE_W-1:0] =
                              {`IO_RSVD, s.io[3], `IO_RSVD, s.io[2]};
            `OFS_COUNTER: reg_read[`CNT_W-1:0] = s.counter;
            `OFS_GR_A:    reg_read[`CNT_W-1:0] = s.gr[0];
            `OFS_GR_B:    reg_read[`CNT_W-1:0] = s.gr[1];
            `OFS_GR_C:    reg_read[`CNT_W-1:0] = s.gr[2];
            `OFS_GR_D:    reg_read[`CNT_W-1:0] = s.gr[3];
            default:      reg_read = '0;
        endcase
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                merge[b*8 +: 8] = data[b*8 +: 8];
            end
        end
    endfunction

    // Pins cross in through two flops; third stage only feeds edge detect
    always_ff @(posedge aclk)
    begin
        pin_s1 <= timer_pin_in;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        ext_s1 <= ext_count_in;
        ext_s2 <= ext_s1;
        ext_s3 <= ext_s2;
    end

    // Bus channels
    always_comb
    begin
        next_wreq     = wreq;
        next_aw_full  = aw_full;
        next_w_full   = w_full;
        next_wr_state = wr_state;
        next_bresp    = bresp;
        next_rd_state = rd_state;
        next_rdata    = rdata;
        next_rresp    = rresp;
        wr_do         = 1'b0;
        rd_do         = 1'b0;
        if (awvalid && awready)
        begin
            next_wreq.addr = awaddr;
            next_aw_full   = 1'b1;
        end
        if (wvalid && wready)
        begin
            next_wreq.data = wdata;
            next_wreq.strb = wstrb;
            next_w_full    = 1'b1;
        end
        case (wr_state)
            timer_pkg::BUS_IDLE:
            begin
                if (next_aw_full && next_w_full)
                begin
                    wr_do         = addr_ok(next_wreq.addr);
                    next_bresp    = wr_do ? `RESP_OKAY : `RESP_SLVERR;
                    next_aw_full  = 1'b0;
                    next_w_full   = 1'b0;
                    next_wr_state = timer_pkg::BUS_RESP;
                end
            end
            timer_pkg::BUS_RESP:
            begin
                if (bready)
                begin
                    next_wr_state = timer_pkg::BUS_IDLE;
                end
            end
            default: next_wr_state = timer_pkg::BUS_IDLE;
        endcase
        case (rd_state)
            timer_pkg::BUS_IDLE:
            begin
                if (arvalid)
                begin
                    rd_do         = addr_ok(araddr);
                    next_rdata    = reg_read(st, araddr);
                    next_rresp    = rd_do ? `RESP_OKAY : `RESP_SLVERR;
                    next_rd_state = timer_pkg::BUS_RESP;
                end
            end
            timer_pkg::BUS_RESP:
            begin
                if (rready)
                begin
                    next_rd_state = timer_pkg::BUS_IDLE;
                end
            end
            default: next_rd_state = timer_pkg::BUS_IDLE;
        endcase
        // Only one write in flight: address and data wait out the response
        next_awready = ~next_aw_full & (next_wr_state == timer_pkg::BUS_IDLE);
        next_wready  = ~next_w_full & (next_wr_state == timer_pkg::BUS_IDLE);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wreq     <= '0;
            aw_full  <= 1'b0;
            w_full   <= 1'b0;
            wr_state <= timer_pkg::BUS_IDLE;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bresp    <= `RESP_OKAY;
            rd_state <= timer_pkg::BUS_IDLE;
            rdata    <= '0;
            rresp    <= `RESP_OKAY;
        end
        else
        begin
            wreq     <= next_wreq;
            aw_full  <= next_aw_full;
            w_full   <= next_w_full;
            wr_state <= next_wr_state;
            awready  <= next_awready;
            wready   <= next_wready;
            bresp    <= next_bresp;
            rd_state <= next_rd_state;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
        end
    end

    assign bvalid  = (wr_state == timer_pkg::BUS_RESP);
    assign arready = (rd_state == timer_pkg::BUS_IDLE);
    assign rvalid  = (rd_state == timer_pkg::BUS_RESP);
    assign cnt_wr  = wr_do && (next_wreq.addr == `OFS_COUNTER);
    assign wimg    = merge(reg_read(st, next_wreq.addr),
                           next_wreq.data, next_wreq.strb);

    // Channel events
    always_comb
    begin
        pwm = {st.mode[`MODE_PWM_D], st.mode[`MODE_PWM_C],
               st.mode[`MODE_PWM_B], 1'b0};
        active = {~st.mode[`MODE_BUF_B], ~st.mode[`MODE_BUF_A], 2'b11};
        tick = st.mode[`MODE_START] &
               (st.control[`CTL_EXT] ? (ext_s2 & ~ext_s3) : 1'b1);
        for (int ch = 0; ch < 4; ch++)
        begin
            cap_mode[ch] = st.io[ch][`IO_CAP_BIT] & ~pwm[ch] &
                           ~(ch == 0 && pwm != 4'h0);
            if (st.io[ch][`IC_BOTH_BIT])
                edge_seen[ch] = pin_s2[ch] ^ pin_s3[ch];
            else if (st.io[ch][`IC_FALL_BIT])
                edge_seen[ch] = ~pin_s2[ch] & pin_s3[ch];
            else
                edge_seen[ch] = pin_s2[ch] & ~pin_s3[ch];
            cap_ev[ch] = active[ch] & cap_mode[ch] & edge_seen[ch];
            // Match fires on the tick that leaves the matching count
            match[ch] = active[ch] & ~cap_mode[ch] & tick &
                        (st.counter == st.gr[ch]);
        end
    end

    // Timer state; hardware updates come last so they win over CPU writes, except counting and pin levels
    always_comb
    begin
        next_st = st;
        if (rd_do && araddr == `OFS_STATUS)
        begin
            next_st.armed = st.status;
        end
        if (wr_do)
        begin
            case (next_wreq.addr)
                `OFS_MODE:    next_st.mode = wimg[`MODE_W-1:0];
                `OFS_CONTROL:
                begin
                    next_st.control = wimg[`CTL_W-1:0];
                    next_st.pin = wimg[`CTL_INIT_LSB +: 4];
                end
                `OFS_IRQ_EN:  next_st.irq_en = wimg[`FLAG_W-1:0];
                `OFS_STATUS:
                begin
                    next_st.status = st.status &
                                     ~(st.armed & ~wimg[`FLAG_W-1:0]);
                    next_st.armed = '0;
                end
                `OFS_IO_AB:
                begin
                    next_st.io[0] = wimg[`IO_W-1:0];
                    next_st.io[1] = wimg[`IO_HI_LSB +: `IO_W];
                end
                `OFS_IO_CD:
                begin
                    next_st.io[2] = wimg[`IO_W-1:0];
                    next_st.io[3] = wimg[`IO_HI_LSB +: `IO_W];
                end
                `OFS_COUNTER: next_st.counter = wimg[`CNT_W-1:0];
                `OFS_GR_A:    next_st.gr[0] = wimg[`CNT_W-1:0];
                `OFS_GR_B:    next_st.gr[1] = wimg[`CNT_W-1:0];
                `OFS_GR_C:    next_st.gr[2] = wimg[`CNT_W-1:0];
                `OFS_GR_D:    next_st.gr[3] = wimg[`CNT_W-1:0];
                default:      next_st.mode = st.mode;
            endcase
        end
        // A counter write wins over counting, a clear wins over both
        if (tick && !cnt_wr)
        begin
            next_st.counter = `CNT_W'(st.counter + 1'b1);
        end
        if (match[0] && st.control[`CTL_CLEAR])
        begin
            next_st.counter = `RST_CNT;
        end
        if (tick && st.counter == `CNT_MAX)
        begin
            next_st.status[`FLAG_OVF] = 1'b1;
        end
        for (int ch = 0; ch < 4; ch++)
        begin
            if (match[ch] || cap_ev[ch])
            begin
                next_st.status[ch] = 1'b1;
            end
            if (cap_ev[ch])
            begin
                next_st.gr[ch] = st.counter;
            end
            next_st.oe[ch] = ~cap_mode[ch];
            // A control write in the same cycle keeps the init level
            if (!(wr_do && next_wreq.addr == `OFS_CONTROL))
            begin
                if (pwm[ch])
                begin
                    if (st.gr[ch] == st.gr[0])
                        next_st.pin[ch] = st.pin[ch];
                    else if (match[0])
                        next_st.pin[ch] = st.control[`CTL_INIT_LSB + ch];
                    else if (match[ch])
                        next_st.pin[ch] = ~st.control[`CTL_INIT_LSB + ch];
                end
                else if (match[ch])
                begin
                    case (st.io[ch][1:0])
                        `OC_LOW:    next_st.pin[ch] = 1'b0;
                        `OC_HIGH:   next_st.pin[ch] = 1'b1;
                        `OC_TOGGLE: next_st.pin[ch] = ~st.pin[ch];
                        default:    next_st.pin[ch] = st.pin[ch];
                    endcase
                end
            end
        end
        if (st.mode[`MODE_BUF_A])
        begin
            if (cap_ev[0])
                next_st.gr[2] = st.gr[0];
            else if (match[0])
                next_st.gr[0] = st.gr[2];
        end
        if (st.mode[`MODE_BUF_B])
        begin
            if (cap_ev[1])
                next_st.gr[3] = st.gr[1];
            else if (match[1])
                next_st.gr[1] = st.gr[3];
        end
        next_st.irq = |(next_st.status & next_st.irq_en);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    assign timer_pin_out     = st.pin;
    assign timer_pin_oe      = st.oe;
    assign timer_irq_request = st.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    count_hold_a: assert property (!st.mode[`MODE_START] && !cnt_wr
        |=> st.counter == $past(st.counter))
        else $error("counter moved while stopped");
    overflow_set_a: assert property (tick && st.counter == `CNT_MAX
        |=> st.status[`FLAG_OVF])
        else $error("overflow flag not set on wrap");
    clear_a_a: assert property (match[0] && st.control[`CTL_CLEAR]
        |=> st.counter == `RST_CNT)
        else $error("counter not cleared at match A");
    match_flag_a: assert property (match[0] |=> st.status[0])
        else $error("match flag A not set");
    capture_b_a: assert property (cap_ev[1]
        |=> st.gr[1] == $past(st.counter))
        else $error("capture B missed counter value");
    buf_capture_a: assert property (cap_ev[0] && st.mode[`MODE_BUF_A]
        |=> st.gr[2] == $past(st.gr[0]) && st.gr[0] == $past(st.counter))
        else $error("capture buffer move wrong");
    pwm_period_a: assert property (pwm[1] && match[0] && !wr_do
        && st.gr[1] != st.gr[0]
        |=> timer_pin_out[1] == st.control[`CTL_INIT_LSB + 1])
        else $error("PWM B wrong level at period");
    irq_join_a: assert property (timer_irq_request
        |-> (st.status & st.irq_en) != '0)
        else $error("irq without enabled flag");
    flag_clear_a: assert property ($fell(st.status[0])
        |-> $past(st.armed[0]))
        else $error("flag cleared without read");
    bus_resp_a: assert property (awvalid && awready ##0 wvalid && wready
        |=> bvalid)
        else $error("no write response");

    overflow_c: cover property (tick && st.counter == `CNT_MAX);
    capture_c: cover property (cap_ev[0] && st.mode[`MODE_BUF_A]);
    pwm_c: cover property (pwm[1] && match[0] ##[1:20] match[1]);
    clear_c: cover property ($fell(st.status[0]));
endmodule

//--- timer_compare_capture_pwm_tb.sv
// Self-checking bench for the timer block
`timescale 1ns/1ns
`include "timer_consts.svh"
module timer_compare_capture_pwm_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, ext;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, v, u;
    logic [1:0]  bresp, rresp, r, wresp;
    logic [3:0]  pin_in, pin_out, pin_oe, want;
    logic [31:0] seed = 32'h777f_267f;
    int          num_errors = 0;
    int          tests_run = 0;
    int          i, g, h, c;

    timer_compare_capture_pwm u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_count_in(ext), .timer_pin_in(pin_in),
        .timer_pin_out(pin_out), .timer_pin_oe(pin_oe),
        .timer_irq_request(irq)
    );
    timer_pins u_pins (
        .aclk(aclk), .want_level(want), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in)
    );

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed & 32'h0000_FFFF;
    endfunction

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic hang();
        num_errors++;
        $display("CHECK FAILED wait expected done seen timeout");
        end_of_test();
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (bvalid)
                break;
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
        end
        wresp = bresp;
        bready <= 1'b0;
        if (n == 50)
            hang();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat,
                      output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (rvalid)
                break;
            arvalid <= arvalid & ~arready;
        end
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n == 50)
            hang();
    endtask

    // Cycles until pin b changes level; a first call only synchronises
    task automatic gap(input int b, output int n);
        logic p;
        p = pin_out[b];
        for (n = 1; n < 100; n++)
        begin
            @(posedge aclk);
            if (pin_out[b] !== p)
                break;
        end
        if (n == 100)
            hang();
    endtask

    // Two PWM periods of ten: high cycles and level changes on pin b
    task automatic watch(output int hi, output int ch);
        logic p;
        hi = 0;
        ch = 0;
        p = pin_out[1];
        repeat (20)
        begin
            @(posedge aclk);
            hi += int'(pin_out[1] === 1'b1);
            ch += int'(pin_out[1] !== p);
            p = pin_out[1];
        end
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ext} = 7'h00;
        {awaddr, araddr, wdata, want} = 52'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            rd(`OFS_GR_A + 8'(4 * i), d, r);
            chk("general reset", d, 32'h0000_FFFF);
        end
        rd(8'h2C, d, r);
        chk("unmapped resp", 32'(r), 32'(`RESP_SLVERR));
        wr(8'h2C, 32'h0000_0000);
        chk("unmapped write", 32'(wresp), 32'(`RESP_SLVERR));
        rd(`OFS_COUNTER, d, r);
        chk("stopped counter", d, 32'h0000_0000);
        // Every output code, one match from level 0
        for (i = 0; i < 4; i++)
        begin
            wr(`OFS_MODE, 32'h0000_0000);
            wr(`OFS_CONTROL, 32'h0000_0000);
            chk("initial level", 32'(pin_out[0]), 32'h0000_0000);
            wr(`OFS_IO_AB, 32'(i));
            // Counter leaves 1 well before the stop write lands
            wr(`OFS_GR_A, 32'h0000_0001);
            wr(`OFS_COUNTER, 32'h0000_0000);
            wr(`OFS_MODE, 32'h0000_0001);
            wr(`OFS_MODE, 32'h0000_0000);
            chk("match level", 32'(pin_out[0]), 32'(i >= 2));
        end
        // Periodic count of N = 5 seen as toggle spacing
        wr(`OFS_IRQ_EN, 32'h0000_0001);
        wr(`OFS_CONTROL, 32'h0000_0001);
        wr(`OFS_IO_AB, 32'h0000_0003);
        wr(`OFS_GR_A, 32'h0000_0005);
        wr(`OFS_COUNTER, 32'h0000_0000);
        wr(`OFS_MODE, 32'h0000_0001);
        gap(0, g);
        gap(0, g);
        chk("period", 32'(g), 32'd6);
        chk("match irq", 32'(irq), 32'h0000_0001);
        wr(`OFS_MODE, 32'h0000_0000);
        wr(`OFS_STATUS, 32'h0000_0000);
        rd(`OFS_STATUS, d, r);
        chk("unread flag", d & 32'h1, 32'h0000_0001);
        wr(`OFS_STATUS, 32'h0000_0000);
        rd(`OFS_STATUS, d, r);
        chk("flag cleared", d & 32'h1, 32'h0000_0000);
        // Wrap past all ones
        wr(`OFS_CONTROL, 32'h0000_0000);
        wr(`OFS_IRQ_EN, 32'h0000_0010);
        wr(`OFS_COUNTER, 32'h0000_FFFD);
        wr(`OFS_MODE, 32'h0000_0001);
        wr(`OFS_MODE, 32'h0000_0000);
        rd(`OFS_STATUS, d, r);
        chk("overflow", d & 32'h10, 32'h0000_0010);
        chk("overflow irq", 32'(irq), 32'h0000_0001);
        // The wrap also matched b at all ones; clear so capture sets it anew
        wr(`OFS_STATUS, 32'h0000_0000);
        // Capture of a stopped counter: rising on b, both edges on a
        wr(`OFS_IO_AB, 32'h0000_0040);
        v = rnd();
        wr(`OFS_COUNTER, v);
        want <= 4'h2;
        repeat (8) @(posedge aclk);
        rd(`OFS_GR_B, d, r);
        chk("capture b", d, v);
        rd(`OFS_STATUS, d, r);
        chk("capture flag", d & 32'h2, 32'h0000_0002);
        wr(`OFS_COUNTER, rnd());
        want <= 4'h0;
        repeat (8) @(posedge aclk);
        rd(`OFS_GR_B, d, r);
        chk("falling ignored", d, v);
        wr(`OFS_MODE, 32'h0000_0002);
        wr(`OFS_IO_AB, 32'h0000_0046);
        u = rnd();
        wr(`OFS_GR_A, u);
        v = rnd();
        wr(`OFS_COUNTER, v);
        want <= 4'h1;
        repeat (8) @(posedge aclk);
        rd(`OFS_GR_A, d, r);
        chk("buffered capture", d, v);
        rd(`OFS_GR_C, d, r);
        chk("buffer holds old", d, u);
        // External count clock, each level held two clocks
        wr(`OFS_CONTROL, 32'h0000_0002);
        wr(`OFS_COUNTER, 32'h0000_0000);
        wr(`OFS_MODE, 32'h0000_0001);
        repeat (5)
        begin
            ext <= 1'b1;
            repeat (2) @(posedge aclk);
            ext <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        repeat (2) @(posedge aclk);
        wr(`OFS_MODE, 32'h0000_0000);
        rd(`OFS_COUNTER, d, r);
        chk("external count", d, 32'h0000_0005);
        // PWM on b, its field set to capture and ignored
        wr(`OFS_MODE, 32'h0000_0000);
        wr(`OFS_CONTROL, 32'h0000_0009);
        wr(`OFS_IO_AB, 32'h0000_0050);
        wr(`OFS_GR_A, 32'h0000_0009);
        wr(`OFS_GR_B, 32'h0000_0003);
        wr(`OFS_COUNTER, 32'h0000_0000);
        wr(`OFS_MODE, 32'h0000_0009);
        gap(1, g);
        watch(h, c);
        chk("pwm high", 32'(h), 32'd8);
        chk("pwm b driven", 32'(pin_oe[1]), 32'h0000_0001);
        wr(`OFS_GR_D, 32'h0000_0006);
        wr(`OFS_MODE, 32'h0000_000D);
        repeat (12) @(posedge aclk);
        rd(`OFS_GR_B, d, r);
        chk("duty reloaded", d, 32'h0000_0006);
        watch(h, c);
        chk("pwm high new", 32'(h), 32'd14);
        wr(`OFS_MODE, 32'h0000_0009);
        wr(`OFS_GR_B, 32'h0000_0009);
        repeat (12) @(posedge aclk);
        watch(h, c);
        chk("duty at period", 32'(c), 32'd0);
        end_of_test();
    end
endmodule

//--- timer_consts.svh
// Register offsets, field positions, encodings and reset values
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define OFS_MODE     8'h00
`define OFS_CONTROL  8'h04
`define OFS_IRQ_EN   8'h08
`define OFS_STATUS   8'h0C
`define OFS_IO_AB    8'h10
`define OFS_IO_CD    8'h14
`define OFS_COUNTER  8'h18
`define OFS_GR_A     8'h1C
`define OFS_GR_B     8'h20
`define OFS_GR_C     8'h24
`define OFS_GR_D     8'h28
`define MODE_W       6
`define MODE_START   0
`define MODE_BUF_A   1
`define MODE_BUF_B   2
`define MODE_PWM_B   3
`define MODE_PWM_C   4
`define MODE_PWM_D   5
`define CTL_W        6
`define CTL_CLEAR    0
`define CTL_EXT      1
`define CTL_INIT_LSB 2
`define FLAG_W       5
`define FLAG_OVF     4
`define IO_W         3
`define IO_HI_LSB    4
`define IO_BYTE_W    8
`define IO_RSVD      1'b1
`define IO_CAP_BIT   2
`define IC_BOTH_BIT  1
`define IC_FALL_BIT  0
`define OC_NONE      2'b00
`define OC_LOW       2'b01
`define OC_HIGH      2'b10
`define OC_TOGGLE    2'b11
`define CNT_W        16
`define CNT_MAX      16'hFFFF
`define RST_CNT      16'h0000
`define RST_GR       16'hFFFF
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

//--- timer_pins.sv
// Pin model standing outside the timer: capture inputs and wire levels
`timescale 1ns/1ns
module timer_pins (
    input  wire logic       aclk,
    input  wire logic [3:0] want_level,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_in
);
    logic [3:0] level = 4'h0;
    int         hold = 0;
    // Each new level must stand three clocks, so hasty requests are delayed
    always @(posedge aclk)
    begin
        hold <= hold + 1;
        if (want_level != level && hold >= 2)
        begin
            level <= want_level;
            hold <= 0;
        end
    end
    // A pin driven by the timer shows its driven level on the wire
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule

//--- timer_pkg.sv
// Types shared by the timer block
package timer_pkg;
    typedef logic [15:0] count_t;
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_RESP = 2'b10} bus_state_e;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wr_req_s;
    typedef struct packed {
        logic [5:0]       mode;
        logic [5:0]       control;
        logic [4:0]       irq_en;
        logic [4:0]       status;
        logic [4:0]       armed;
        logic [3:0][2:0]  io;
        count_t           counter;
        logic [3:0][15:0] gr;
        logic [3:0]       pin;
        logic [3:0]       oe;
        logic             irq;
    } timer_state_s;
endpackage
